// File: src/compare_channel.sv
// One compare channel: match detect, match event and waveform
`timescale 1ns/100ps
`default_nettype none
module compare_channel (
   input wire logic clk,
   input wire logic rst_n,
   compare_if.channel cif
);
   logic [9:0] eff_value;
   logic hit;
   logic hit_q;
   logic wave_q;

   // Enhanced mode drops the extra low bit from the match compare
   always_comb begin
      eff_value = cif.enhanced ? cif.value[10:1] : cif.value[9:0];
      hit = (cif.count == eff_value) && !cif.blocked;
   end

   // Match seen on a tick, event on the following tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_q <= 1'b0;
      end else if (cif.tick) begin
         hit_q <= hit;
      end
   end

   // Output high from BOTTOM until the match
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wave_q <= 1'b0;
      end else if (cif.tick) begin
         if (hit) begin
            wave_q <= 1'b0;
         end else if (cif.count == high_speed_timer_pkg::BOTTOM_VALUE) begin
            wave_q <= 1'b1;
         end
      end
   end

   assign cif.match_event = cif.tick && hit_q;
   assign cif.wave = wave_q;
endmodule
`default_nettype wire

// File: src/compare_if.sv
// Carrier between the timer core and one compare channel
`timescale 1ns/100ps
`default_nettype none
interface compare_if;
   logic [10:0] value;
   logic enhanced;
   logic [9:0] count;
   logic tick;
   logic blocked;
   logic match_event;
   logic wave;
   modport core (output value, output enhanced, output count, output tick, output blocked,
      input match_event, input wave);
   modport channel (input value, input enhanced, input count, input tick, input blocked,
      output match_event, output wave);
endinterface
`default_nettype wire

// File: src/high_speed_timer_core.sv
// Top of the high speed timer core with byte register port
`timescale 1ns/100ps
`default_nettype none
module high_speed_timer_core (
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic FAST_CLOCK,
   input wire logic FAULT_IN,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WSTROBE,
   input wire logic RSTROBE,
   output logic [7:0] RDATA,
   output logic IRQ,
   output logic WAVE_A,
   output logic WAVE_B,
   output logic WAVE_D,
   output logic BOTTOM
);
   // CPU side registers
   logic [2:0] hbuf_q;
   logic [10:0] ca_q;
   logic [10:0] cb_q;
   logic [10:0] cd_q;
   logic [9:0] top_q;
   logic [3:0] flags_q;
   logic [7:0] masks_q;
   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] ctrl_c_q;
   logic [7:0] ctrl_d_q;
   logic fault_flag_q;
   logic cw_req_q;
   logic [9:0] cw_data_q;
   logic [7:0] rd_d;
   logic irq_d;
   logic wr_low;
   logic [7:0] wr_data;
   // Counting side
   logic [48:0] cfg_cpu;
   logic [48:0] cfg_s;
   logic [10:0] cw_s;
   logic cw_we;
   logic [9:0] cw_data;
   logic enh_s;
   logic async_s;
   logic [3:0] cs_s;
   logic [9:0] top_s;
   logic [10:0] ca_s;
   logic [10:0] cb_s;
   logic [10:0] cd_s;
   logic [9:0] cnt_q;
   logic [9:0] cnt_d;
   logic block_q;
   logic [14:0] presc_q;
   logic [14:0] presc_mask;
   logic src_tick;
   logic tick;
   logic wrap;
   logic ovf_event;
   logic [9:0] cnt_rd;
   logic [3:0] flags_rd;
   logic [2:0] hbuf_rd;
   // Pin synchronisers
   logic fclk_s1_q;
   logic fclk_s2_q;
   logic fclk_s3_q;
   logic fclk_lvl_q;
   logic fast_rise;
   logic flt_s1_q;
   logic flt_s2_q;
   logic flt_s3_q;
   logic flt_lvl_q;
   logic fault_rise;

   compare_if cif_a();
   compare_if cif_b();
   compare_if cif_d();

   // Three flops on each pin; a change counts once stages two and three agree
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         fclk_s1_q <= 1'b0;
         fclk_s2_q <= 1'b0;
         fclk_s3_q <= 1'b0;
         fclk_lvl_q <= 1'b0;
         flt_s1_q <= 1'b0;
         flt_s2_q <= 1'b0;
         flt_s3_q <= 1'b0;
         flt_lvl_q <= 1'b0;
      end else begin
         fclk_s1_q <= FAST_CLOCK;
         fclk_s2_q <= fclk_s1_q;
         fclk_s3_q <= fclk_s2_q;
         flt_s1_q <= FAULT_IN;
         flt_s2_q <= flt_s1_q;
         flt_s3_q <= flt_s2_q;
         if (fclk_s2_q == fclk_s3_q) begin
            fclk_lvl_q <= fclk_s3_q;
         end
         if (flt_s2_q == flt_s3_q) begin
            flt_lvl_q <= flt_s3_q;
         end
      end
   end

   assign fast_rise = (fclk_s2_q == fclk_s3_q) && fclk_s3_q && !fclk_lvl_q;
   assign fault_rise = (flt_s2_q == flt_s3_q) && flt_s3_q && !flt_lvl_q;

   // Low byte write joins the shared upper bits
   assign wr_low = WSTROBE;
   assign wr_data = WDATA;

   // Wide registers and shared buffer
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         hbuf_q <= 3'h0;
         ca_q <= 11'h000;
         cb_q <= 11'h000;
         cd_q <= 11'h000;
         top_q <= high_speed_timer_pkg::TOP_RESET;
         cw_data_q <= 10'h000;
      end else if (wr_low) begin
         case (ADDR)
            high_speed_timer_pkg::OFS_HIGH: hbuf_q <= wr_data[2:0];
            high_speed_timer_pkg::OFS_COUNT: cw_data_q <= {hbuf_q[1:0], wr_data};
            high_speed_timer_pkg::OFS_CMP_A: ca_q <= {hbuf_q, wr_data};
            high_speed_timer_pkg::OFS_CMP_B: cb_q <= {hbuf_q, wr_data};
            high_speed_timer_pkg::OFS_CMP_D: cd_q <= {hbuf_q, wr_data};
            high_speed_timer_pkg::OFS_TOP: top_q <= {hbuf_q[1:0], wr_data};
            default: hbuf_q <= hbuf_q;
         endcase
      end else if (RSTROBE) begin
         case (ADDR)
            high_speed_timer_pkg::OFS_COUNT: hbuf_q <= {1'b0, cnt_rd[9:8]};
            high_speed_timer_pkg::OFS_CMP_A: hbuf_q <= ca_q[10:8];
            high_speed_timer_pkg::OFS_CMP_B: hbuf_q <= cb_q[10:8];
            high_speed_timer_pkg::OFS_CMP_D: hbuf_q <= cd_q[10:8];
            high_speed_timer_pkg::OFS_TOP: hbuf_q <= {1'b0, top_q[9:8]};
            default: hbuf_q <= hbuf_q;
         endcase
      end
   end

   // Counter write request, one cycle
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         cw_req_q <= 1'b0;
      end else begin
         cw_req_q <= WSTROBE && (ADDR == high_speed_timer_pkg::OFS_COUNT);
      end
   end

   // Control registers
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_a_q <= 8'h00;
         ctrl_b_q <= 8'h00;
         ctrl_c_q <= 8'h00;
         ctrl_d_q <= 8'h00;
         masks_q <= 8'h00;
      end else if (WSTROBE) begin
         case (ADDR)
            high_speed_timer_pkg::OFS_CTRL_A: ctrl_a_q <= WDATA;
            high_speed_timer_pkg::OFS_CTRL_B: ctrl_b_q <= WDATA;
            high_speed_timer_pkg::OFS_CTRL_C: ctrl_c_q <= WDATA;
            high_speed_timer_pkg::OFS_CTRL_D: ctrl_d_q <= WDATA;
            high_speed_timer_pkg::OFS_MASKS: masks_q <= {4'h0, WDATA[3:0]};
            default: masks_q <= masks_q;
         endcase
      end
   end

   // Sticky flags, write one to clear, a set in the same cycle wins
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         flags_q <= 4'h0;
         fault_flag_q <= 1'b0;
      end else begin
         if (WSTROBE && (ADDR == high_speed_timer_pkg::OFS_FLAGS)) begin
            flags_q <= (flags_q & ~WDATA[3:0]) |
               {cif_d.match_event, cif_b.match_event, cif_a.match_event, ovf_event};
         end else begin
            flags_q <= flags_q |
               {cif_d.match_event, cif_b.match_event, cif_a.match_event, ovf_event};
         end
         if (WSTROBE && (ADDR == high_speed_timer_pkg::OFS_CTRL_D)) begin
            fault_flag_q <= (fault_flag_q & ~WDATA[high_speed_timer_pkg::CTRL_D_FAULT_FLAG])
               | fault_rise;
         end else begin
            fault_flag_q <= fault_flag_q | fault_rise;
         end
      end
   end

   // Interrupt from unmasked flags and the fault source
   always_comb begin
      irq_d = |(flags_q & masks_q[3:0]) |
         (fault_flag_q & ctrl_d_q[high_speed_timer_pkg::CTRL_D_FAULT_EN]);
   end

   // Read data: config at once, counter, buffer and flags delayed
   always_comb begin
      rd_d = 8'h00;
      if (RSTROBE) begin
         case (ADDR)
            high_speed_timer_pkg::OFS_COUNT: rd_d = cnt_rd[7:0];
            high_speed_timer_pkg::OFS_HIGH: rd_d = {5'h00, hbuf_rd};
            high_speed_timer_pkg::OFS_CMP_A: rd_d = ca_q[7:0];
            high_speed_timer_pkg::OFS_CMP_B: rd_d = cb_q[7:0];
            high_speed_timer_pkg::OFS_TOP: rd_d = top_q[7:0];
            high_speed_timer_pkg::OFS_CMP_D: rd_d = cd_q[7:0];
            high_speed_timer_pkg::OFS_FLAGS: rd_d = {4'h0, flags_rd};
            high_speed_timer_pkg::OFS_MASKS: rd_d = masks_q;
            high_speed_timer_pkg::OFS_CTRL_A: rd_d = ctrl_a_q;
            high_speed_timer_pkg::OFS_CTRL_B: rd_d = ctrl_b_q;
            high_speed_timer_pkg::OFS_CTRL_C: rd_d = ctrl_c_q;
            high_speed_timer_pkg::OFS_CTRL_D: rd_d = {ctrl_d_q[7], fault_flag_q, ctrl_d_q[5:0]};
            default: rd_d = 8'h00;
         endcase
      end
   end

   // Registered outputs toward the CPU
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= 8'h00;
         IRQ <= 1'b0;
      end else begin
         RDATA <= rd_d;
         IRQ <= irq_d;
      end
   end

   // Written values cross into the counting side
   assign cfg_cpu = {ctrl_a_q[high_speed_timer_pkg::CTRL_A_ENH],
      ctrl_b_q[high_speed_timer_pkg::CTRL_B_ASYNC], ctrl_b_q[3:0], top_q, ca_q, cb_q, cd_q};
   sync_stage #(.WIDTH(49)) u_cfg_sync (.clk(CLOCK), .rst_n(RESETN), .din(cfg_cpu),
      .dout(cfg_s));
   sync_stage #(.WIDTH(11)) u_cw_sync (.clk(CLOCK), .rst_n(RESETN),
      .din({cw_req_q, cw_data_q}), .dout(cw_s));
   assign {enh_s, async_s, cs_s, top_s, ca_s, cb_s, cd_s} = cfg_s;
   assign {cw_we, cw_data} = cw_s;

   // Values read back through the output stages
   sync_stage #(.WIDTH(17)) u_rd_sync (.clk(CLOCK), .rst_n(RESETN),
      .din({cnt_q, flags_q, hbuf_q}), .dout({cnt_rd, flags_rd, hbuf_rd}));

   // Timer clock source and prescaler
   always_comb begin
      src_tick = async_s ? fast_rise : 1'b1;
      presc_mask = (15'h0001 << (cs_s - high_speed_timer_pkg::CS_DIV1)) - 15'h0001;
      tick = (cs_s != high_speed_timer_pkg::CS_STOP) && src_tick &&
         ((presc_q & presc_mask) == presc_mask);
   end

   // Prescaler runs only while a source is selected
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         presc_q <= 15'h0000;
      end else if (cs_s == high_speed_timer_pkg::CS_STOP) begin
         presc_q <= 15'h0000;
      end else if (src_tick) begin
         presc_q <= presc_q + 15'h0001;
      end
   end

   // Next counter value: write first, then clear at TOP or MAX, then count
   always_comb begin
      wrap = (cnt_q == top_s) || (cnt_q == high_speed_timer_pkg::MAX_VALUE);
      cnt_d = cnt_q;
      if (cw_we) begin
         cnt_d = cw_data;
      end else if (tick && wrap) begin
         cnt_d = high_speed_timer_pkg::BOTTOM_VALUE;
      end else if (tick) begin
         cnt_d = cnt_q + 10'h001;
      end
   end

   assign ovf_event = tick && !cw_we && wrap;

   // Counter, match blocking after a write, and BOTTOM
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_q <= high_speed_timer_pkg::BOTTOM_VALUE;
         block_q <= 1'b0;
         BOTTOM <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         if (cw_we) begin
            block_q <= 1'b1;
         end else if (tick) begin
            block_q <= 1'b0;
         end
         BOTTOM <= (cnt_d == high_speed_timer_pkg::BOTTOM_VALUE);
      end
   end

   // Compare channels A, B and D
   assign cif_a.value = ca_s;
   assign cif_b.value = cb_s;
   assign cif_d.value = cd_s;
   assign cif_a.enhanced = enh_s;
   assign cif_b.enhanced = enh_s;
   assign cif_d.enhanced = enh_s;
   assign cif_a.count = cnt_q;
   assign cif_b.count = cnt_q;
   assign cif_d.count = cnt_q;
   assign cif_a.tick = tick && !cw_we;
   assign cif_b.tick = tick && !cw_we;
   assign cif_d.tick = tick && !cw_we;
   assign cif_a.blocked = block_q;
   assign cif_b.blocked = block_q;
   assign cif_d.blocked = block_q;
   compare_channel u_ch_a (.clk(CLOCK), .rst_n(RESETN), .cif(cif_a));
   compare_channel u_ch_b (.clk(CLOCK), .rst_n(RESETN), .cif(cif_b));
   compare_channel u_ch_d (.clk(CLOCK), .rst_n(RESETN), .cif(cif_d));
   assign WAVE_A = cif_a.wave;
   assign WAVE_B = cif_b.wave;
   assign WAVE_D = cif_d.wave;

   default clocking cb_main @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);

   sequence s_write_a;
      WSTROBE && (ADDR == high_speed_timer_pkg::OFS_CMP_A);
   endsequence
   sequence s_read_a;
      RSTROBE && (ADDR == high_speed_timer_pkg::OFS_CMP_A);
   endsequence
   sequence s_write_top;
      WSTROBE && (ADDR == high_speed_timer_pkg::OFS_TOP);
   endsequence

   a_top_clears_counter:
   assert property (tick && !cw_we && (cnt_q == top_s) |=> cnt_q == 10'h000)
      else $error("counter not cleared at TOP");
   a_max_wraps_zero:
   assert property (tick && !cw_we && (cnt_q == 10'h3FF) |=> cnt_q == 10'h000)
      else $error("counter not wrapped at MAX");
   a_stopped_holds_count:
   assert property ((cs_s == 4'h0) && !cw_we |=> $stable(cnt_q))
      else $error("counter moved while stopped");
   a_write_beats_count:
   assert property (cw_we |=> cnt_q == $past(cw_data))
      else $error("counter write lost");
   a_bottom_at_zero:
   assert property (cnt_q == 10'h000 |-> BOTTOM)
      else $error("BOTTOM missing at zero");
   a_compare_readback_now:
   assert property (s_write_a ##1 s_read_a |=> RDATA == $past(WDATA, 2))
      else $error("compare A read back wrong");
   a_low_read_loads_high:
   assert property (s_read_a |=> hbuf_q == $past(ca_q[10:8]))
      else $error("buffer not loaded on low read");
   a_top_sync_delay:
   assert property (s_write_top ##1 1'b1 |-> ##2 top_s == $past(top_q, 2))
      else $error("TOP not passed through sync stages");
   a_match_sets_flag:
   assert property (cif_a.match_event |=> flags_q[1])
      else $error("match A flag not set");
   a_irq_follows_mask:
   assert property ((flags_q & masks_q[3:0]) != 4'h0 |=> IRQ)
      else $error("interrupt not raised");
endmodule
`default_nettype wire

// File: src/high_speed_timer_pkg.sv
// Constants, offsets and reset values of the high speed timer core
// Function
// - Ten-bit counter acts as eight-bit when upper bits are written zero.
// - One shared high-bits buffer carries upper bits over the byte bus.
// - Reading a wide register's low byte loads its upper bits into the buffer.
// - Enhanced mode compares bits 10:1 of the eleven-bit A, B, D values with the counter.
// - Compares A, B, D each drive their own pin and match flag.
// - Compare C holds TOP; counter clears on matching it.
// - Five maskable interrupt sources; fault flag and enable sit in control D.
// - Asynchronous mode counts on the fast clock behind a sync boundary.
// - Written values pass sync stages before they affect counting.
// - Control and compare registers read back new value right after write, except control D bit 6, which reads the fault flag.
// - Counter, buffer and match/overflow flags read back through sync delay.
// - Signal BOTTOM when the counter is zero.
// - Counter value 0x3FF is the maximum.
// - TOP resets to 0x0FF and is the highest count value.
// - Clock select zero stops counting; counter stays accessible.
// - Counter write beats clear and count in the same timer clock.
package high_speed_timer_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int CNT_W = 10;
   localparam int CMP_W = 11;
   localparam int HIGH_W = 3;
   localparam int PRESC_W = 15;
   // Register offsets
   localparam logic [3:0] OFS_COUNT = 4'h0;
   localparam logic [3:0] OFS_HIGH = 4'h1;
   localparam logic [3:0] OFS_CMP_A = 4'h2;
   localparam logic [3:0] OFS_CMP_B = 4'h3;
   localparam logic [3:0] OFS_TOP = 4'h4;
   localparam logic [3:0] OFS_CMP_D = 4'h5;
   localparam logic [3:0] OFS_FLAGS = 4'h6;
   localparam logic [3:0] OFS_MASKS = 4'h7;
   localparam logic [3:0] OFS_CTRL_A = 4'h8;
   localparam logic [3:0] OFS_CTRL_B = 4'h9;
   localparam logic [3:0] OFS_CTRL_C = 4'hA;
   localparam logic [3:0] OFS_CTRL_D = 4'hB;
   // Field positions
   localparam int FLAG_OVF = 0;
   localparam int FLAG_A = 1;
   localparam int FLAG_B = 2;
   localparam int FLAG_D = 3;
   localparam int CTRL_A_ENH = 0;
   localparam int CTRL_B_ASYNC = 7;
   localparam int CTRL_D_FAULT_FLAG = 6;
   localparam int CTRL_D_FAULT_EN = 7;
   // Values
   localparam logic [9:0] TOP_RESET = 10'h0FF;
   localparam logic [9:0] MAX_VALUE = 10'h3FF;
   localparam logic [9:0] BOTTOM_VALUE = 10'h000;
   localparam logic [3:0] CS_STOP = 4'h0;
   localparam logic [3:0] CS_DIV1 = 4'h1;
   localparam int CLOCK_PERIOD_NS = 20;
   localparam int FAST_CLOCK_MAX_MHZ = 64;
endpackage

// File: src/placeholder_none.sv
// Empty unit kept for compile ordering
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: src/sync_stage.sv
// Two register stages between the CPU side and the counting side
`timescale 1ns/100ps
`default_nettype none
module sync_stage #(parameter int WIDTH = 1) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage_q;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_q <= '0;
         dout <= '0;
      end else begin
         stage_q <= din;
         dout <= stage_q;
      end
   end
endmodule
`default_nettype wire

// File: verification/cpu_bus_model.sv
// Byte bus master standing in for the CPU core
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
   input wire logic clk,
   output logic [3:0] addr,
   output logic [7:0] wdata,
   output logic wstrobe,
   output logic rstrobe,
   input wire logic [7:0] rdata
);
   // Idle bus at time zero
   initial begin
      addr = 4'h0;
      wdata = 8'h00;
      wstrobe = 1'b0;
      rstrobe = 1'b0;
   end
   // One write cycle, one idle edge before returning
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wstrobe <= 1'b1;
      @(posedge clk);
      wstrobe <= 1'b0;
      @(posedge clk);
   endtask
   // Write then read back at the very next edge, no gap between strobes
   task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
      addr <= a;
      wdata <= d;
      wstrobe <= 1'b1;
      @(posedge clk);
      wstrobe <= 1'b0;
      rstrobe <= 1'b1;
      @(posedge clk);
      rstrobe <= 1'b0;
      @(posedge clk);
      q = rdata;
   endtask
   // One read cycle, data taken at the edge after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      addr <= a;
      rstrobe <= 1'b1;
      @(posedge clk);
      rstrobe <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
   // Wide write: upper bits into the shared buffer first
   task automatic wr_wide(input logic [3:0] a, input logic [10:0] v);
      wr(high_speed_timer_pkg::OFS_HIGH, {5'h00, v[10:8]});
      wr(a, v[7:0]);
   endtask
   // Wide read: low byte, then buffer once its sync delay is over
   task automatic rd_wide(input logic [3:0] a, output logic [10:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(a, lo);
      @(posedge clk);
      @(posedge clk);
      rd(high_speed_timer_pkg::OFS_HIGH, hi);
      v = {hi[2:0], lo};
   endtask
endmodule
`default_nettype wire

// File: verification/high_speed_timer_core_tb_top.sv
// Self-checking bench for the high speed timer core
`timescale 1ns/100ps
`default_nettype none
module high_speed_timer_core_tb_top;
   logic CLOCK;
   logic RESETN;
   logic FAST_CLOCK = 1'b0;
   logic FAULT_IN;
   logic [3:0] ADDR;
   logic [7:0] WDATA;
   logic WSTROBE;
   logic RSTROBE;
   logic [7:0] RDATA;
   logic IRQ;
   logic WAVE_A;
   logic WAVE_B;
   logic WAVE_D;
   logic BOTTOM;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   logic [1:0] fast_div = 2'b00;
   logic [7:0] rv;
   logic [10:0] wv;

   high_speed_timer_core dut (.CLOCK(CLOCK), .RESETN(RESETN), .FAST_CLOCK(FAST_CLOCK),
      .FAULT_IN(FAULT_IN), .ADDR(ADDR), .WDATA(WDATA), .WSTROBE(WSTROBE), .RSTROBE(RSTROBE),
      .RDATA(RDATA), .IRQ(IRQ), .WAVE_A(WAVE_A), .WAVE_B(WAVE_B), .WAVE_D(WAVE_D),
      .BOTTOM(BOTTOM));
   cpu_bus_model cpu (.clk(CLOCK), .addr(ADDR), .wdata(WDATA), .wstrobe(WSTROBE),
      .rstrobe(RSTROBE), .rdata(RDATA));

   // System clock, 20 ns
   initial begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end
   // Slow fast-clock source, one rising edge every 8 cycles; hang guard
   always @(posedge CLOCK) begin
      fast_div <= fast_div + 2'b01;
      if (fast_div == 2'b11) FAST_CLOCK <= ~FAST_CLOCK;
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic check(input logic [10:0] got, input logic [10:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge CLOCK);
   endtask
   // Edges until BOTTOM next rises, bounded
   task automatic next_rise(output int k);
      logic prev;
      k = 1;
      prev = BOTTOM;
      @(posedge CLOCK);
      while (!(prev === 1'b0 && BOTTOM === 1'b1) && k < 400) begin
         prev = BOTTOM;
         @(posedge CLOCK);
         k++;
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Reset values and the unmapped space
   task automatic t_reset();
      check(11'(BOTTOM), 11'h001);
      cpu.rd_wide(high_speed_timer_pkg::OFS_TOP, wv);
      check(wv, 11'h0FF);
      cpu.rd(high_speed_timer_pkg::OFS_MASKS, rv);
      check(11'(rv), 11'h000);
      cpu.wr(4'hD, 8'hFF);
      cpu.rd(4'hD, rv);
      check(11'(rv), 11'h000);
      $display("t_reset done");
   endtask
   // Compare and control registers read back at once
   task automatic t_readback();
      logic [7:0] v;
      for (int i = 2; i < 12; i++) begin
         if (i == 6 || i == 7) continue;
         v = (i < 6) ? 8'(8'h30 + i) : ((i == 9 || i == 11) ? 8'h80 : 8'h01);
         cpu.wr_rd(4'(i), v, rv);
         check(11'(rv), 11'(v));
      end
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_A, 8'h00);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_B, 8'h00);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_D, 8'h00);
      $display("t_readback done");
   endtask
   // Ten-bit counter held while stopped, then wraps at the maximum
   task automatic t_wide();
      cpu.wr_wide(high_speed_timer_pkg::OFS_COUNT, 11'h3FA);
      cyc(6);
      cpu.rd_wide(high_speed_timer_pkg::OFS_COUNT, wv);
      check(wv, 11'h3FA);
      cpu.wr_wide(high_speed_timer_pkg::OFS_TOP, 11'h3FF);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_B, 8'h01);
      next_rise(n);
      check(11'(n < 14), 11'h001);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_B, 8'h00);
      cyc(4);
      cpu.rd(high_speed_timer_pkg::OFS_FLAGS, rv);
      check(11'(rv[0]), 11'h001);
      cpu.wr(high_speed_timer_pkg::OFS_FLAGS, 8'h0F);
      $display("t_wide done");
   endtask
   // Count sequence restarts after TOP
   task automatic t_period();
      cpu.wr_wide(high_speed_timer_pkg::OFS_TOP, 11'h00F);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_B, 8'h01);
      next_rise(n);
      next_rise(n);
      check(11'(n), 11'd16);
      // Clock select two halves the tick rate
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_B, 8'h02);
      next_rise(n);
      next_rise(n);
      check(11'(n), 11'd32);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_B, 8'h01);
      $display("t_period done");
   endtask
   // Three compare channels, flags, mask and clear
   task automatic t_compare();
      int a;
      int b;
      int d;
      a = 0;
      b = 0;
      d = 0;
      cpu.wr_wide(high_speed_timer_pkg::OFS_CMP_A, 11'h003);
      cpu.wr_wide(high_speed_timer_pkg::OFS_CMP_B, 11'h005);
      cpu.wr_wide(high_speed_timer_pkg::OFS_CMP_D, 11'h007);
      cyc(40);
      repeat (32) begin
         @(posedge CLOCK);
         a += int'(WAVE_A === 1'b1);
         b += int'(WAVE_B === 1'b1);
         d += int'(WAVE_D === 1'b1);
      end
      check(11'(a), 11'd6);
      check(11'(b), 11'd10);
      check(11'(d), 11'd14);
      check(11'(IRQ), 11'h000);
      cpu.rd(high_speed_timer_pkg::OFS_FLAGS, rv);
      check(11'(rv), 11'h00F);
      cpu.wr(high_speed_timer_pkg::OFS_MASKS, 8'h02);
      cyc(2);
      check(11'(IRQ), 11'h001);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_B, 8'h00);
      cyc(4);
      cpu.wr(high_speed_timer_pkg::OFS_FLAGS, 8'h0F);
      cyc(4);
      cpu.rd(high_speed_timer_pkg::OFS_FLAGS, rv);
      check(11'(rv), 11'h000);
      check(11'(IRQ), 11'h000);
      cpu.wr(high_speed_timer_pkg::OFS_MASKS, 8'h00);
      $display("t_compare done");
   endtask
   // Fault flag and its enable in control D
   task automatic t_fault();
      FAULT_IN <= 1'b1;
      cyc(8);
      cpu.rd(high_speed_timer_pkg::OFS_CTRL_D, rv);
      check(11'(rv), 11'h040);
      check(11'(IRQ), 11'h000);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_D, 8'h80);
      cyc(2);
      check(11'(IRQ), 11'h001);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_D, 8'hC0);
      cyc(2);
      check(11'(IRQ), 11'h000);
      FAULT_IN <= 1'b0;
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_D, 8'h00);
      $display("t_fault done");
   endtask
   // Extra compare bit in enhanced mode, then counting on the fast clock
   task automatic t_enh_async();
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_A, 8'h01);
      cpu.wr_wide(high_speed_timer_pkg::OFS_CMP_D, 11'h721);
      cpu.rd_wide(high_speed_timer_pkg::OFS_CMP_D, wv);
      check(wv, 11'h721);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_A, 8'h00);
      cpu.wr_wide(high_speed_timer_pkg::OFS_COUNT, 11'h000);
      cpu.wr_wide(high_speed_timer_pkg::OFS_TOP, 11'h003);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_B, 8'h81);
      next_rise(n);
      next_rise(n);
      check(11'(n), 11'd32);
      cpu.wr(high_speed_timer_pkg::OFS_CTRL_B, 8'h00);
      $display("t_enh_async done");
   endtask

   // Main sequence
   initial begin
      RESETN = 1'b0;
      FAULT_IN = 1'b0;
      repeat (3) @(posedge CLOCK);
      RESETN <= 1'b1;
      @(posedge CLOCK);
      t_reset();
      t_readback();
      t_wide();
      t_period();
      t_compare();
      t_fault();
      t_enh_async();
      complete_run();
   end
endmodule
`default_nettype wire
